// ==== src/i2chp_map.svh ====
// Constants of the I2C host peripheral port
`ifndef I2CHP_MAP_SVH
`define I2CHP_MAP_SVH
`define I2CHP_CLK_MHZ          250
`define I2CHP_STRETCH_MAX_MS   20
`define I2CHP_STRETCH_CYC      (`I2CHP_STRETCH_MAX_MS * 1000 * `I2CHP_CLK_MHZ)
`define I2CHP_TSU_DAT_NS       100
`define I2CHP_TSU_CYC          ((`I2CHP_TSU_DAT_NS * `I2CHP_CLK_MHZ + 999) / 1000)
`define I2CHP_ADDR_DEFAULT     7'h42
`define I2CHP_NMEA_DEFAULT     7'h7f
`define I2CHP_IN_PROTO_DEFAULT 3'h7
`define I2CHP_OUT_PROTO_DEFAULT 3'h7
`define I2CHP_VBP_SCHED_DEFAULT 1'b0
`define I2CHP_RTCM_SCHED_DEFAULT 1'b0
`endif

// ==== src/i2chp_pkg.sv ====
// Types of the I2C host peripheral port
package i2chp_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK,
		ST_RX,
		ST_TX,
		ST_TXACK,
		ST_SKIP
	} i2chp_state_type;
endpackage

// ==== src/i2chp_port.sv ====
// I2C target port core with clock stretching and default protocol enables
`timescale 1ns/100ps
`include "i2chp_map.svh"

// Summary of operation
// RULE1: The target decodes Fast-mode timing only and offers no Standard-mode fallback; the code has no timing check and follows bus edges at any rate.
// RULE2: The block is only a target and never drives clocks of its own except stretching low.
// RULE3: The target holds the clock low while its byte source or sink is not ready.
// RULE4: A single clock stretch is forcibly ended after 20 ms.
// RULE5: After a stretch, data is placed on the data line a set-up interval before the clock is freed.
// RULE6: With the host-port select strap at 0 the I2C port is disabled and releases both lines.
// RULE7: The SPI port is enabled only when the strap is low, otherwise UART and I2C stay in use.
// RULE8: The default NMEA sentence set equals the primary serial port set: GGA GLL GSA GSV RMC VTG TXT.
// RULE9: By default all three input protocols are accepted.
// RULE10: Vendor binary and RTCM output are enabled by default with no messages scheduled.
// RULE11: Only the own 7-bit address is acknowledged; other addresses leave the data line released.
module i2chp_port #(
	parameter logic [6:0] OWN_ADDR    = `I2CHP_ADDR_DEFAULT,
	parameter int         STRETCH_CYC = `I2CHP_STRETCH_CYC
) (
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe_o,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	input  wire logic        host_sel_i,
	output logic             i2c_enable_o,
	output logic             spi_enable_o,
	output logic [6:0]       nmea_enable_o,
	output logic [2:0]       in_proto_enable_o,
	output logic [2:0]       out_proto_enable_o,
	output logic [1:0]       msg_sched_o,
	output logic [7:0]       rx_data_o,
	output logic             rx_valid_o,
	input  wire logic        rx_ready_i,
	input  wire logic [7:0]  tx_data_i,
	input  wire logic        tx_valid_i,
	output logic             tx_ready_o,
	output logic             stretch_timeout_o
);
	import i2chp_pkg::*;

	localparam int TSU_CYC = `I2CHP_TSU_CYC;

	i2chp_state_type state_q;
	logic [2:0]  scl_s_q;
	logic [2:0]  sda_s_q;
	logic [2:0]  sel_s_q;
	logic        scl_f_q;
	logic        sda_f_q;
	logic        sel_f_q;
	logic        scl_prev_q;
	logic        sda_prev_q;
	logic [7:0]  shift_q;
	logic [3:0]  bit_q;
	logic        rw_q;
	logic        stretch_q;
	logic [31:0] stretch_cnt_q;
	logic [7:0]  setup_cnt_q;
	logic        sda_drv_q;

	// Qualified line levels: a change counts once the last two stages agree
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
			sel_s_q <= 3'h7;
			scl_f_q <= 1'b1;
			sda_f_q <= 1'b1;
			sel_f_q <= 1'b1;
		end else begin
			scl_s_q <= {scl_s_q[1:0], scl_i};
			sda_s_q <= {sda_s_q[1:0], sda_i};
			sel_s_q <= {sel_s_q[1:0], host_sel_i};
			if (scl_s_q[2] == scl_s_q[1]) scl_f_q <= scl_s_q[2];
			if (sda_s_q[2] == sda_s_q[1]) sda_f_q <= sda_s_q[2];
			if (sel_s_q[2] == sel_s_q[1]) sel_f_q <= sel_s_q[2];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_f_q;
			sda_prev_q <= sda_f_q;
		end
	end

	wire scl_rise = scl_f_q & ~scl_prev_q;
	wire scl_fall = ~scl_f_q & scl_prev_q;
	wire start_c  = scl_f_q & scl_prev_q & sda_prev_q & ~sda_f_q;
	wire stop_c   = scl_f_q & scl_prev_q & ~sda_prev_q & sda_f_q;

	// Strap decode and default protocol settings
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			i2c_enable_o       <= 1'b1;
			spi_enable_o       <= 1'b0;
			nmea_enable_o      <= `I2CHP_NMEA_DEFAULT;
			in_proto_enable_o  <= `I2CHP_IN_PROTO_DEFAULT;
			out_proto_enable_o <= `I2CHP_OUT_PROTO_DEFAULT;
			msg_sched_o        <= {`I2CHP_RTCM_SCHED_DEFAULT, `I2CHP_VBP_SCHED_DEFAULT};
		end else begin
			i2c_enable_o       <= sel_f_q; // [RULE6]
			spi_enable_o       <= ~sel_f_q; // [RULE7]
			nmea_enable_o      <= `I2CHP_NMEA_DEFAULT; // [RULE8]
			in_proto_enable_o  <= `I2CHP_IN_PROTO_DEFAULT; // [RULE9]
			out_proto_enable_o <= `I2CHP_OUT_PROTO_DEFAULT; // [RULE10]
			msg_sched_o        <= {`I2CHP_RTCM_SCHED_DEFAULT, `I2CHP_VBP_SCHED_DEFAULT}; // [RULE10]
		end
	end

	wire need_stretch = ((state_q == ST_RX) && rx_valid_o && !rx_ready_i) ||
		((state_q == ST_TX) && (bit_q == 4'h0) && tx_ready_o);

	// Byte state machine, sampling on the bus rise and shifting on the fall
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || !i2c_enable_o) begin
			state_q    <= ST_IDLE; // [RULE6]
			shift_q    <= 8'h00;
			bit_q      <= 4'h0;
			rw_q       <= 1'b0;
			rx_data_o  <= 8'h00;
			rx_valid_o <= 1'b0;
			tx_ready_o <= 1'b0;
		end else begin
			if (rx_valid_o && rx_ready_i) rx_valid_o <= 1'b0;
			if (tx_ready_o && tx_valid_i) begin
				tx_ready_o <= 1'b0;
				shift_q    <= tx_data_i;
			end
			if (stop_c) begin
				state_q <= ST_IDLE;
			end else if (start_c) begin
				state_q <= ST_ADDR;
				bit_q   <= 4'h0;
			end else begin
				unique case (state_q)
					ST_IDLE, ST_SKIP: begin
					end
					ST_ADDR, ST_RX: begin
						if (scl_rise) begin
							shift_q <= {shift_q[6:0], sda_f_q};
							bit_q   <= bit_q + 4'h1;
						end
						if (scl_fall && bit_q == 4'h8) begin
							bit_q <= 4'h0;
							if (state_q == ST_ADDR) begin
								if (shift_q[7:1] == OWN_ADDR) begin // [RULE11]
									rw_q    <= shift_q[0];
									state_q <= ST_ACK;
								end else begin
									state_q <= ST_SKIP; // [RULE11]
								end
							end else begin
								rx_data_o  <= shift_q;
								rx_valid_o <= 1'b1;
								state_q    <= ST_ACK;
							end
						end
					end
					ST_ACK: begin
						if (scl_fall) begin
							state_q    <= rw_q ? ST_TX : ST_RX;
							tx_ready_o <= rw_q;
						end
					end
					ST_TX: begin
						if (scl_fall && !tx_ready_o) begin
							if (bit_q == 4'h7) begin
								state_q <= ST_TXACK;
								bit_q   <= 4'h0;
							end else begin
								shift_q <= {shift_q[6:0], 1'b1};
								bit_q   <= bit_q + 4'h1;
							end
						end
					end
					// Ready only after the acknowledge clock falls, so an early byte never meets a high clock
					ST_TXACK: begin
						if (scl_rise && sda_f_q) state_q <= ST_SKIP;
						if (scl_fall) begin
							state_q    <= ST_TX;
							tx_ready_o <= 1'b1;
						end
					end
				endcase
			end
		end
	end

	// Stretch control; timeout lets a lost host recover instead of hanging the bus
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || !i2c_enable_o) begin
			stretch_q         <= 1'b0;
			stretch_cnt_q     <= 32'h0;
			setup_cnt_q       <= 8'h00;
			stretch_timeout_o <= 1'b0;
		end else begin
			stretch_timeout_o <= 1'b0;
			if (!scl_f_q && need_stretch && !stretch_q && stretch_cnt_q == 32'h0) begin
				stretch_q   <= 1'b1; // [RULE3]
				setup_cnt_q <= 8'h00;
			end else if (stretch_q) begin
				stretch_cnt_q <= stretch_cnt_q + 32'h1;
				if (stretch_cnt_q >= 32'(STRETCH_CYC - 1)) begin
					stretch_q         <= 1'b0; // [RULE4]
					stretch_timeout_o <= 1'b1;
				end else if (!need_stretch) begin
					if (setup_cnt_q >= 8'(TSU_CYC)) stretch_q <= 1'b0; // [RULE5]
					else setup_cnt_q <= setup_cnt_q + 8'h01;
				end else begin
					setup_cnt_q <= 8'h00;
				end
			end else if (scl_f_q) begin
				stretch_cnt_q <= 32'h0;
			end
		end
	end

	// Line drivers: only ever pull low, the controller owns the clock [RULE2]
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || !i2c_enable_o) begin
			sda_drv_q <= 1'b0;
		end else begin
			sda_drv_q <= (state_q == ST_ACK) ||
				((state_q == ST_TX) && !tx_ready_o && !shift_q[7]);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			scl_o    <= 1'b0;
			scl_oe_o <= 1'b0;
			sda_o    <= 1'b0;
			sda_oe_o <= 1'b0;
		end else begin
			scl_o    <= 1'b0;
			sda_o    <= 1'b0;
			scl_oe_o <= stretch_q & i2c_enable_o; // [RULE3]
			sda_oe_o <= sda_drv_q & i2c_enable_o; // [RULE6]
		end
	end

	property p_disabled_release;
		@(posedge ref_clk_i) disable iff (reset_i)
		!i2c_enable_o |=> !sda_oe_o && !scl_oe_o;
	endproperty
	a_disabled_release: assert property (p_disabled_release) else $error("lines driven while disabled"); // [RULE6]

	property p_spi_excl;
		@(posedge ref_clk_i) disable iff (reset_i)
		spi_enable_o != i2c_enable_o;
	endproperty
	a_spi_excl: assert property (p_spi_excl) else $error("spi and i2c both selected"); // [RULE7]

	property p_nmea_def;
		@(posedge ref_clk_i) disable iff (reset_i)
		nmea_enable_o == 7'h7f && in_proto_enable_o == 3'h7;
	endproperty
	a_nmea_def: assert property (p_nmea_def) else $error("default enables wrong"); // [RULE8]

	property p_sched_def;
		@(posedge ref_clk_i) disable iff (reset_i)
		msg_sched_o == 2'h0 && out_proto_enable_o == 3'h7;
	endproperty
	a_sched_def: assert property (p_sched_def) else $error("messages scheduled by default"); // [RULE10]

	property p_skip_quiet;
		@(posedge ref_clk_i) disable iff (reset_i)
		state_q == ST_SKIP ##1 state_q == ST_SKIP |=> !sda_oe_o;
	endproperty
	a_skip_quiet: assert property (p_skip_quiet) else $error("data driven for foreign address"); // [RULE11]

	property p_stretch_bound;
		@(posedge ref_clk_i) disable iff (reset_i)
		stretch_q |-> stretch_cnt_q < 32'(STRETCH_CYC);
	endproperty
	a_stretch_bound: assert property (p_stretch_bound) else $error("stretch too long"); // [RULE4]

	sequence s_released;
		stretch_q && i2c_enable_o ##1 !stretch_q;
	endsequence
	property p_setup;
		@(posedge ref_clk_i) disable iff (reset_i)
		s_released ##0 !stretch_timeout_o |-> $past(setup_cnt_q) >= 8'(TSU_CYC);
	endproperty
	a_setup: assert property (p_setup) else $error("clock freed before data set-up"); // [RULE5]

	property p_stretch_oe;
		@(posedge ref_clk_i) disable iff (reset_i)
		stretch_q && i2c_enable_o |=> scl_oe_o;
	endproperty
	a_stretch_oe: assert property (p_stretch_oe) else $error("stretch not on clock line"); // [RULE3]

	property p_data_steady;
		@(posedge ref_clk_i) disable iff (reset_i)
		scl_f_q && scl_prev_q |-> !$rose(sda_oe_o);
	endproperty
	a_data_steady: assert property (p_data_steady) else $error("data pulled low while clock high"); // [RULE5]
endmodule

// ==== verif/i2chp_ctrl_model.sv ====
// Behavioural I2C controller on the far side of the port
`timescale 1ns/100ps
module i2chp_ctrl_model (
	input  wire logic ref_clk_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_drv_o,
	output logic      sda_drv_o
);
	int n_stretch;
	int n_hang;
	initial begin
		scl_drv_o = 1'b1;
		sda_drv_o = 1'b1;
		n_stretch = 0;
		n_hang = 0;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	// Waits out a stretch; the bound sits well past the shortened limit
	task automatic rise();
		int k;
		k = 0;
		scl_drv_o = 1'b1;
		hold(1);
		while (scl_i !== 1'b1 && k < 2000) begin
			hold(1);
			k++;
		end
		if (k > 8) n_stretch++;
		if (k >= 2000) n_hang++;
	endtask
	// Low 1.4 us, high 1.2 us stays under 400 kbit/s
	task automatic bit_io(input logic b, output logic r);
		hold(25);
		sda_drv_o = b;
		hold(325);
		rise();
		hold(150);
		r = sda_i;
		hold(150);
		scl_drv_o = 1'b0;
	endtask
	task automatic start();
		sda_drv_o = 1'b1;
		hold(25);
		rise();
		hold(150);
		sda_drv_o = 1'b0;
		hold(150);
		scl_drv_o = 1'b0;
	endtask
	task automatic stop();
		hold(25);
		sda_drv_o = 1'b0;
		hold(325);
		rise();
		hold(150);
		sda_drv_o = 1'b1;
		hold(325);
	endtask
	task automatic byte_io(input logic [7:0] d, input logic m, output logic [7:0] q, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(m, a);
		ack = !a;
	endtask
endmodule

// ==== verif/i2chp_port_tb.sv ====
// Self-checking bench of the I2C host peripheral port
`timescale 1ns/100ps
module i2chp_port_tb;
	import i2chp_pkg::*;
	logic       ref_clk_i, reset_i, host_sel_i, rx_ready_i, tx_valid_i, ack, scl_m, sda_m;
	logic       scl_o, scl_oe_o, sda_o, sda_oe_o, i2c_enable_o, spi_enable_o, rx_valid_o, tx_ready_o;
	logic       stretch_timeout_o;
	logic [7:0] tx_data_i, rx_data_o, q, rd0, rd1;
	logic [6:0] nmea_enable_o;
	logic [2:0] in_proto_enable_o, out_proto_enable_o;
	logic [1:0] msg_sched_o;
	logic [7:0] wr [3];
	int         n_mismatch, checks, n_to;
	// Pull-ups: a released line reads high
	wire        scl = scl_m & ~scl_oe_o;
	wire        sda = sda_m & ~sda_oe_o;
	i2chp_port #(.OWN_ADDR(7'h42), .STRETCH_CYC(1000)) i_dut (
		.ref_clk_i, .reset_i, .scl_i(scl), .scl_o, .scl_oe_o, .sda_i(sda), .sda_o, .sda_oe_o,
		.host_sel_i, .i2c_enable_o, .spi_enable_o, .nmea_enable_o, .in_proto_enable_o,
		.out_proto_enable_o, .msg_sched_o, .rx_data_o, .rx_valid_o, .rx_ready_i, .tx_data_i,
		.tx_valid_i, .tx_ready_o, .stretch_timeout_o);
	i2chp_ctrl_model i_ctrl (.ref_clk_i, .scl_i(scl), .sda_i(sda), .scl_drv_o(scl_m), .sda_drv_o(sda_m));
	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) if (stretch_timeout_o === 1'b1) n_to++;
	function automatic logic [7:0] ab(input logic [6:0] a, input logic rd);
		return {a, rd};
	endfunction
	task automatic cmp1(input logic g, input logic e, input string m);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic cmp8(input logic [7:0] g, input logic [7:0] e, input string m);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic wait_sig(input logic tx);
		int k;
		k = 0;
		while ((tx ? tx_ready_o : rx_valid_o) !== 1'b1 && k < 30000) begin
			@(negedge ref_clk_i);
			k++;
		end
		if (k >= 30000) begin
			n_mismatch++;
			$display("MISMATCH %0t handshake wait limit", $time);
		end
	endtask
	task automatic ack_rx();
		@(negedge ref_clk_i);
		rx_ready_i = 1'b1;
		@(negedge ref_clk_i);
		rx_ready_i = 1'b0;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// About 75k cycles of traffic are expected
	initial begin
		#400000;
		n_mismatch++;
		results();
	end
	initial begin
		{reset_i, host_sel_i, rx_ready_i, tx_valid_i, tx_data_i, n_mismatch, checks, n_to} = '0;
		reset_i = 1'b1;
		host_sel_i = 1'b1;
		void'($urandom(32'hbddd59cd));
		foreach (wr[i]) wr[i] = 8'($urandom);
		wr[1] = 8'h00;
		rd0 = 8'($urandom);
		rd1 = 8'h01;
		repeat (20) @(negedge ref_clk_i);
		reset_i = 1'b0;
		repeat (10) @(negedge ref_clk_i);
		cmp8({1'b0, nmea_enable_o}, 8'h7f, "nmea set");
		cmp8({5'h0, in_proto_enable_o}, 8'h07, "in proto");
		cmp8({5'h0, out_proto_enable_o}, 8'h07, "out proto");
		cmp8({6'h0, msg_sched_o}, 8'h00, "schedule");
		cmp1(i2c_enable_o, 1'b1, "i2c on");
		cmp1(spi_enable_o, 1'b0, "spi off");
		// Sink lags on later bytes so the next byte is stretched, short of the limit
		fork
			begin
				i_ctrl.start();
				i_ctrl.byte_io(ab(7'h42, 1'b0), 1'b1, q, ack);
				cmp1(ack, 1'b1, "addr ack");
				foreach (wr[i]) begin
					i_ctrl.byte_io(wr[i], 1'b1, q, ack);
					cmp1(ack, 1'b1, "data ack");
				end
				i_ctrl.stop();
			end
			foreach (wr[i]) begin
				wait_sig(1'b0);
				cmp8(rx_data_o, wr[i], "rx data");
				repeat (i == 0 ? 100 : 1100 + i * 100) @(negedge ref_clk_i);
				ack_rx();
			end
		join
		cmp1(i_ctrl.n_stretch == 2, 1'b1, "stretch count");
		cmp1(n_to == 0, 1'b1, "early timeout");
		i_ctrl.start();
		i_ctrl.byte_io(ab(7'h42 ^ (7'h01 << ($urandom % 7)), 1'b0), 1'b1, q, ack);
		cmp1(ack, 1'b0, "foreign ack");
		i_ctrl.stop();
		fork
			begin
				i_ctrl.start();
				i_ctrl.byte_io(ab(7'h42, 1'b1), 1'b1, q, ack);
				cmp1(ack, 1'b1, "read addr ack");
				i_ctrl.byte_io(8'hff, 1'b0, q, ack);
				cmp8(q, rd0, "read byte 0");
				i_ctrl.byte_io(8'hff, 1'b1, q, ack);
				cmp8(q, rd1, "read byte 1");
				i_ctrl.stop();
			end
			for (int i = 0; i < 2; i++) begin
				wait_sig(1'b1);
				repeat (400) @(negedge ref_clk_i);
				tx_data_i = i ? rd1 : rd0;
				tx_valid_i = 1'b1;
				do @(negedge ref_clk_i); while (tx_ready_o === 1'b1);
				tx_valid_i = 1'b0;
			end
		join
		host_sel_i = 1'b0;
		repeat (20) @(negedge ref_clk_i);
		cmp1(i2c_enable_o, 1'b0, "i2c off");
		cmp1(spi_enable_o, 1'b1, "spi on");
		i_ctrl.start();
		i_ctrl.byte_io(ab(7'h42, 1'b0), 1'b1, q, ack);
		cmp1(ack, 1'b0, "ack while off");
		i_ctrl.stop();
		host_sel_i = 1'b1;
		repeat (20) @(negedge ref_clk_i);
		cmp1(i2c_enable_o, 1'b1, "i2c back");
		// Unread byte: the next byte is held until the stretch limit cuts it, then the sink catches up
		fork
			begin
				i_ctrl.start();
				i_ctrl.byte_io(ab(7'h42, 1'b0), 1'b1, q, ack);
				i_ctrl.byte_io(wr[0], 1'b1, q, ack);
				i_ctrl.byte_io(8'h5a, 1'b1, q, ack);
				cmp1(ack, 1'b1, "ack after cut");
				i_ctrl.stop();
			end
			begin
				wait_sig(1'b0);
				wait (n_to == 1);
				cmp8(rx_data_o, wr[0], "held byte");
				ack_rx();
				wait_sig(1'b0);
				cmp8(rx_data_o, 8'h5a, "byte after cut");
				ack_rx();
			end
		join
		cmp1(n_to == 1, 1'b1, "timeout pulse");
		cmp1(i_ctrl.n_hang == 0, 1'b1, "clock held too long");
		cmp1(scl_o | sda_o, 1'b0, "pins only pull low");
		results();
	end
endmodule
